//--- src/bank_protect.sv
// protection and bypass relay drive for one row bank
`timescale 1ns/100ps
`default_nettype none
module bank_protect #(
  parameter int SETTLE = relay_pkg::SETTLE_CYC
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // bank state
  input  wire relay_pkg::prot_mode_e mode,
  input  wire logic                  mode_chg,
  input  wire logic                  any_closed,
  input  wire logic                  close_evt,
  // relay drive
  output logic                       protect,
  output logic                       bypass
);

  logic [15:0] tmr_q;
  logic        protect_q;
  logic        bypass_q;

  // the momentary timer restarts on every new close in the bank, except a close in a cycle with mode_chg high
  always_ff @(posedge clk) begin
    if (rst || mode_chg || mode != relay_pkg::MODE_MOMENTARY) begin
      tmr_q <= 16'h0000;
    end else if (close_evt) begin
      tmr_q <= 16'(SETTLE);
    end else if (tmr_q != 16'h0000) begin
      tmr_q <= tmr_q - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      protect_q <= 1'b0;
      bypass_q  <= 1'b0;
    end else begin
      unique case (mode)
        relay_pkg::MODE_BANK_ACTIVE: begin
          protect_q <= any_closed || close_evt;
          bypass_q  <= 1'b0;
        end
        relay_pkg::MODE_MOMENTARY: begin
          protect_q <= close_evt || (tmr_q > 16'h0001);
          bypass_q  <= any_closed && !close_evt && (tmr_q <= 16'h0001);
        end
        relay_pkg::MODE_ALWAYS_IN: begin
          protect_q <= 1'b1;
          bypass_q  <= 1'b0;
        end
        relay_pkg::MODE_SPLIT: begin
          protect_q <= 1'b0;
          bypass_q  <= 1'b0;
        end
      endcase
    end
  end

  assign protect = protect_q;
  assign bypass  = bypass_q;

endmodule
`default_nettype wire

//--- src/relay_matrix_ctrl.sv
// crosspoint relay drive with close limit, interlock and row protection
`timescale 1ns/100ps
`default_nettype none
module relay_matrix_ctrl #(
  parameter int SETTLE = relay_pkg::SETTLE_CYC
) (
  // clock and reset
  input  wire logic                      SYS_CLK,
  input  wire logic                      RST,
  // safety interlock continuity
  input  wire logic                      FACE_LOOP_OK,
  input  wire logic                      EXT_LOOP_OK,
  // host requests
  input  wire relay_pkg::chan_req_s      REQ,
  input  wire logic                      MODE_WR,
  input  wire relay_pkg::prot_mode_e     MODE_IN,
  // status toward the host
  output logic                           CLOSE_ERR,
  output logic                           INTERLOCK_ERR,
  output logic [relay_pkg::CNT_W-1:0]    CLOSED_CNT,
  output relay_pkg::prot_mode_e          MODE_OUT,
  // relay drive
  output logic [relay_pkg::NUM_XPOINTS-1:0] XPOINT,
  output relay_pkg::bank_drive_s         BANK_DRV
);

  localparam int NB = relay_pkg::NUM_BANKS;

  logic [relay_pkg::NUM_XPOINTS-1:0] xp_q;
  logic [relay_pkg::CNT_W-1:0]       cnt_q;
  relay_pkg::prot_mode_e             mode_q;
  logic                              mode_chg_q;
  logic                              cerr_q;
  logic                              ierr_q;
  logic                              ilk_ok;
  logic                              is_closed;
  logic                              do_close;
  logic                              do_open;
  logic [NB-1:0]                     bank_any;
  logic [NB-1:0]                     bank_evt;
  logic [NB-1:0]                     bank_prot;
  logic [NB-1:0]                     bank_byp;

  assign ilk_ok    = FACE_LOOP_OK && EXT_LOOP_OK;
  assign is_closed = xp_q[REQ.chan];
  // a close of an already closed channel is harmless and not counted
  assign do_close  = REQ.close && ilk_ok && !is_closed
                     && (cnt_q < relay_pkg::CNT_W'(relay_pkg::MAX_CLOSED));
  assign do_open   = REQ.open && !REQ.close && is_closed && ilk_ok;

  //////////////////////////////////////////////////////////////////////////////
  // crosspoints and count; the interlock wins over everything
  always_ff @(posedge SYS_CLK) begin
    if (RST || !ilk_ok) begin
      xp_q <= '0;
    end else if (do_close) begin
      xp_q[REQ.chan] <= 1'b1;
    end else if (do_open) begin
      xp_q[REQ.chan] <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST || !ilk_ok) begin
      cnt_q <= relay_pkg::CNT_RST;
    end else if (do_close) begin
      cnt_q <= cnt_q + relay_pkg::CNT_W'(1);
    end else if (do_open) begin
      cnt_q <= cnt_q - relay_pkg::CNT_W'(1);
    end
  end

  // one-cycle error pulses; a refused close leaves the channel open
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      cerr_q <= 1'b0;
      ierr_q <= 1'b0;
    end else begin
      cerr_q <= REQ.close && ilk_ok && !is_closed
                && (cnt_q >= relay_pkg::CNT_W'(relay_pkg::MAX_CLOSED));
      ierr_q <= REQ.close && !ilk_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // single module-wide mode; split mode validity is the host's concern
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mode_q     <= relay_pkg::prot_mode_e'(relay_pkg::MODE_RST);
      mode_chg_q <= 1'b0;
    end else begin
      mode_chg_q <= MODE_WR && (MODE_IN != mode_q);
      if (MODE_WR) begin
        mode_q <= MODE_IN;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-bank protection
  generate
    for (genvar b = 0; b < NB; b++) begin : g_bank
      assign bank_any[b] = |xp_q[b*relay_pkg::BANK_COLS +: relay_pkg::BANK_COLS];
      assign bank_evt[b] = do_close && (REQ.chan[relay_pkg::CH_W-1:5] == 4'(b));
      bank_protect #(
        .SETTLE     (SETTLE)
      ) bank_protect_i (
        .clk        (SYS_CLK),
        .rst        (RST),
        .mode       (mode_q),
        .mode_chg   (mode_chg_q),
        .any_closed (bank_any[b]),
        .close_evt  (bank_evt[b]),
        .protect    (bank_prot[b]),
        .bypass     (bank_byp[b])
      );
    end
  endgenerate

  // the drive struct gets one whole driver rather than one per bit
  assign BANK_DRV      = '{protect: bank_prot, bypass: bank_byp};
  assign XPOINT        = xp_q;
  assign CLOSED_CNT    = cnt_q;
  assign MODE_OUT      = mode_q;
  assign CLOSE_ERR     = cerr_q;
  assign INTERLOCK_ERR = ierr_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_full_close;
    REQ.close && ilk_ok && !is_closed && cnt_q >= 10'h040;
  endsequence

  property p_interlock_open;
    @(posedge SYS_CLK) disable iff (RST) !ilk_ok |=> (xp_q == '0 && cnt_q == 10'h000);
  endproperty
  a_interlock_open: assert property (p_interlock_open) else $error("relays not opened");

  property p_limit;
    @(posedge SYS_CLK) disable iff (RST) cnt_q <= 10'h040;
  endproperty
  a_limit: assert property (p_limit) else $error("more than 64 closed");

  property p_refuse;
    @(posedge SYS_CLK) disable iff (RST) s_full_close |=> CLOSE_ERR && !xp_q[$past(REQ.chan)];
  endproperty
  a_refuse: assert property (p_refuse) else $error("65th close not refused");

  property p_count_match;
    @(posedge SYS_CLK) disable iff (RST) do_close |=> cnt_q == $past(cnt_q) + 10'h001;
  endproperty
  a_count_match: assert property (p_count_match) else $error("count did not follow close");

  property p_ilk_refuse;
    @(posedge SYS_CLK) disable iff (RST) (REQ.close && !ilk_ok) |=> INTERLOCK_ERR && xp_q == '0;
  endproperty
  a_ilk_refuse: assert property (p_ilk_refuse) else $error("close during open loop");

  property p_active;
    @(posedge SYS_CLK) disable iff (RST)
      (mode_q == relay_pkg::MODE_BANK_ACTIVE && !MODE_WR && bank_any[0])
      |=> BANK_DRV.protect[0];
  endproperty
  a_active: assert property (p_active) else $error("protect open with bank active");

  property p_always;
    @(posedge SYS_CLK) disable iff (RST)
      (mode_q == relay_pkg::MODE_ALWAYS_IN && !MODE_WR)[*2] |-> BANK_DRV.protect == '1;
  endproperty
  a_always: assert property (p_always) else $error("always-in protect open");

  property p_split;
    @(posedge SYS_CLK) disable iff (RST)
      (mode_q == relay_pkg::MODE_SPLIT && !MODE_WR)[*2] |-> (BANK_DRV.protect == '0
      && BANK_DRV.bypass == '0);
  endproperty
  a_split: assert property (p_split) else $error("split mode relay closed");

  property p_moment;
    @(posedge SYS_CLK) disable iff (RST)
      (mode_q == relay_pkg::MODE_MOMENTARY && bank_evt != '0)
      |=> ((BANK_DRV.protect & $past(bank_evt)) == $past(bank_evt))
      && ((BANK_DRV.bypass & $past(bank_evt)) == '0);
  endproperty
  a_moment: assert property (p_moment) else $error("momentary protect missing");

  property p_active_close;
    @(posedge SYS_CLK) disable iff (RST)
      (mode_q == relay_pkg::MODE_BANK_ACTIVE && bank_evt != '0)
      |=> (BANK_DRV.protect & $past(bank_evt)) == $past(bank_evt);
  endproperty
  a_active_close: assert property (p_active_close) else $error("bank protect not closed");

  property p_exclusive;
    @(posedge SYS_CLK) disable iff (RST) (BANK_DRV.protect & BANK_DRV.bypass) == '0;
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("protect and bypass both on");

  property p_open_count;
    @(posedge SYS_CLK) disable iff (RST) do_open |=> cnt_q == $past(cnt_q) - 10'h001;
  endproperty
  a_open_count: assert property (p_open_count) else $error("count did not follow open");

  property p_hold;
    @(posedge SYS_CLK) disable iff (RST)
      (ilk_ok && !do_close && !do_open) |=> XPOINT == $past(XPOINT);
  endproperty
  a_hold: assert property (p_hold) else $error("crosspoint moved without a request");

  property p_no_err;
    @(posedge SYS_CLK) disable iff (RST) !REQ.close |=> !CLOSE_ERR && !INTERLOCK_ERR;
  endproperty
  a_no_err: assert property (p_no_err) else $error("error pulse without a close");

  // a write that really changes the mode must also clear the bank timers
  sequence s_mode_write;
    MODE_WR && MODE_IN != mode_q;
  endsequence

  property p_mode_write;
    @(posedge SYS_CLK) disable iff (RST)
      s_mode_write |=> mode_chg_q && MODE_OUT == $past(MODE_IN);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

endmodule
`default_nettype wire

//--- src/relay_pkg.sv
// constants and types for the crosspoint relay drive and row protection controller
package relay_pkg;

  localparam int NUM_XPOINTS   = 512;
  localparam int BANK_COLS     = 32;
  localparam int NUM_BANKS     = NUM_XPOINTS / BANK_COLS;
  localparam int MAX_CLOSED    = 64;
  localparam int CH_W          = 9;
  localparam int CNT_W         = 10;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_US     = 1;
  localparam int SETTLE_CYC    = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [CNT_W-1:0] CNT_RST  = 10'h000;
  localparam logic [1:0]       MODE_RST = 2'h0;

  typedef enum logic [1:0] {
    MODE_BANK_ACTIVE = 2'h0,
    MODE_MOMENTARY   = 2'h1,
    MODE_ALWAYS_IN   = 2'h2,
    MODE_SPLIT       = 2'h3
  } prot_mode_e;

  typedef struct packed {
    logic            close;
    logic            open;
    logic [CH_W-1:0] chan;
  } chan_req_s;

  typedef struct packed {
    logic [NUM_BANKS-1:0] protect;
    logic [NUM_BANKS-1:0] bypass;
  } bank_drive_s;

endpackage

//--- testbench/host_model.sv
// host-side model issuing channel and mode requests
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock
  input  wire logic             clk,
  // requests toward the switch module
  output relay_pkg::chan_req_s  req,
  output relay_pkg::prot_mode_e mode_in,
  output logic                  mode_wr
);
  initial begin
    req = '0;
    mode_in = relay_pkg::MODE_BANK_ACTIVE;
    mode_wr = 1'h0;
  end
  // one strobe a cycle; a run of sends keeps the strobe up and idle ends it
  task automatic send(input logic cl, input int c);
    req <= '{close: cl, open: ~cl, chan: c[8:0]};
    @(posedge clk);
    #1;
  endtask
  // chan flips once released so a stale value is never trusted
  task automatic idle();
    req <= '{close: 1'h0, open: 1'h0, chan: ~req.chan};
  endtask
  // split only on 32-column setups, always-in only on short rows: caller's duty
  task automatic set_mode(input relay_pkg::prot_mode_e m);
    mode_in <= m;
    mode_wr <= 1'h1;
    @(posedge clk);
    #1 mode_wr <= 1'h0;
    // one quiet edge so a second write never raises the strobe just dropped
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

//--- testbench/relay_matrix_row_protection_ctrl_tb.sv
// self-checking bench for the relay drive and row protection controller
`timescale 1ns/100ps
`default_nettype none
module relay_matrix_row_protection_ctrl_tb;
  // short settle keeps the momentary case quick
  localparam int SETTLE = 3;
  logic                  sys_clk = 1'h0;
  logic                  rst = 1'h1;
  logic                  face_ok = 1'h1;
  logic                  ext_ok = 1'h1;
  relay_pkg::chan_req_s  req;
  relay_pkg::prot_mode_e mode_in;
  logic                  mode_wr;
  logic                  close_err;
  logic                  ilk_err;
  logic [9:0]            cnt;
  relay_pkg::prot_mode_e mode_out;
  logic [511:0]          xpoint;
  relay_pkg::bank_drive_s bank;
  int                    failures = 0;
  int                    comparisons = 0;
  int                    cycles = 0;

  always #5 sys_clk = ~sys_clk;

  host_model host_model_i (.clk(sys_clk), .req(req), .mode_in(mode_in), .mode_wr(mode_wr));

  relay_matrix_ctrl #(.SETTLE(SETTLE)) relay_matrix_ctrl_i (
    .SYS_CLK(sys_clk), .RST(rst), .FACE_LOOP_OK(face_ok), .EXT_LOOP_OK(ext_ok),
    .REQ(req), .MODE_WR(mode_wr), .MODE_IN(mode_in), .CLOSE_ERR(close_err),
    .INTERLOCK_ERR(ilk_err), .CLOSED_CNT(cnt), .MODE_OUT(mode_out),
    .XPOINT(xpoint), .BANK_DRV(bank)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [511:0] seen, input logic [511:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      tally_and_finish();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_bank_active();
    host_model_i.send(1'h1, 5);
    host_model_i.idle();
    check("xpoint5", xpoint[5], 1'h1);
    check("count one", cnt, 10'h001);
    tick(1);
    check("protect", bank.protect, 16'h0001);
    host_model_i.send(1'h1, 6);
    host_model_i.send(1'h0, 5);
    host_model_i.idle();
    tick(1);
    check("protect held", bank.protect[0], 1'h1);
    host_model_i.send(1'h0, 6);
    host_model_i.idle();
    tick(1);
    check("bank released", bank, 32'h0);
    $display("test bank_active done");
  endtask

  task automatic test_limit();
    for (int i = 0; i < 64; i++) host_model_i.send(1'h1, i);
    check("count", cnt, 10'h040);
    host_model_i.send(1'h1, 64);
    host_model_i.idle();
    check("close err", close_err, 1'h1);
    check("ch64", xpoint[64], 1'h0);
    tick(1);
    check("err pulse", close_err, 1'h0);
    check("count kept", cnt, 10'h040);
    $display("test limit done");
  endtask

  task automatic test_interlock();
    face_ok <= 1'h0;
    host_model_i.send(1'h1, 100);
    check("face clear", xpoint, 512'h0);
    check("ilk err", ilk_err, 1'h1);
    face_ok <= 1'h1;
    host_model_i.send(1'h1, 7);
    check("reclose", xpoint[7], 1'h1);
    check("ilk err drop", ilk_err, 1'h0);
    ext_ok <= 1'h0;
    host_model_i.send(1'h1, 8);
    host_model_i.idle();
    check("ext clear", xpoint, 512'h0);
    check("ilk err ext", ilk_err, 1'h1);
    ext_ok <= 1'h1;
    tick(1);
    check("count zero", cnt, 10'h000);
    $display("test interlock done");
  endtask

  task automatic test_modes();
    host_model_i.set_mode(relay_pkg::MODE_ALWAYS_IN);
    check("mode", mode_out, relay_pkg::MODE_ALWAYS_IN);
    check("always in", bank, {16'hFFFF, 16'h0000});
    host_model_i.send(1'h1, 70);
    host_model_i.idle();
    tick(20);
    check("always held", bank, {16'hFFFF, 16'h0000});
    // a reset in mid-run drops the mode back to its reset value
    rst <= 1'h1;
    tick(1);
    rst <= 1'h0;
    check("reset mode", mode_out, relay_pkg::MODE_BANK_ACTIVE);
    check("reset drive", {xpoint[70], bank}, 33'h0);
    tick(1);
    host_model_i.send(1'h1, 70);
    host_model_i.idle();
    tick(1);
    check("bank two", bank, {16'h0004, 16'h0000});
    host_model_i.set_mode(relay_pkg::MODE_SPLIT);
    check("split", bank, 32'h0);
    tick(20);
    check("split held", {xpoint[70], bank}, {1'h1, 32'h0});
    host_model_i.set_mode(relay_pkg::MODE_MOMENTARY);
    host_model_i.send(1'h1, 40);
    host_model_i.idle();
    check("inrush", {bank.protect[1], bank.bypass[1]}, 2'h2);
    tick(SETTLE - 1);
    check("inrush end", {bank.protect[1], bank.bypass[1]}, 2'h2);
    tick(1);
    check("bypassed", {bank.protect[1], bank.bypass[1]}, 2'h1);
    $display("test modes done");
  endtask

  initial begin
    tick(2);
    rst <= 1'h0;
    tick(1);
    test_bank_active();
    test_limit();
    test_interlock();
    test_modes();
    tally_and_finish();
  end
endmodule
`default_nettype wire
